/* dsbg_defines.vh */
// Constants for the disk sector buffer glue block.
// Assumes a single 100 MHz core clock; included by its bare name.
`ifndef DSBG_DEFINES_VH
`define DSBG_DEFINES_VH

// Core clock
`define DSBG_CLK_MHZ          100
`define DSBG_CLK_PERIOD_NS    10

// Wait-state counter clock, made as an enable from the core clock
`define DSBG_WAIT_CLK_MHZ     5
`define DSBG_WAIT_DIV         (`DSBG_CLK_MHZ / `DSBG_WAIT_CLK_MHZ)
`define DSBG_WAIT_DIV_W       5
`define DSBG_WAIT_CNT_W       3
`define DSBG_WAIT_READY_BIT   2

// Write precompensation delay taps
`define DSBG_TAP_EARLY_NS     10
`define DSBG_TAP_LATE_NS      20
`define DSBG_TAP_EARLY_CYC    ((`DSBG_TAP_EARLY_NS + `DSBG_CLK_PERIOD_NS - 1) / `DSBG_CLK_PERIOD_NS)
`define DSBG_TAP_LATE_CYC     ((`DSBG_TAP_LATE_NS + `DSBG_CLK_PERIOD_NS - 1) / `DSBG_CLK_PERIOD_NS)

// Host address decode on address lines 8..4
`define DSBG_DEC_W            5
`define DSBG_CTRL_BASE        5'h00
`define DSBG_PORT_BASE        5'h01
`define DSBG_LOW_BIT_PORT     1'h0
`define DSBG_LOW_BIT_DATA     1'h1

// Control port latch bits
`define DSBG_CP_W             8
`define DSBG_CP_RESET         8'h00
`define DSBG_CP_HEAD_LSB      0
`define DSBG_CP_HEAD_W        3
`define DSBG_CP_CLKSRC        3
`define DSBG_CP_XFER_DONE     4
`define DSBG_CP_CNT_RESET     5
`define DSBG_CP_SPARE_LSB     6

// Buffer geometry
`define DSBG_BYTE_W           9
`define DSBG_BYTE_MAX         9'h1FF
`define DSBG_SECT_W_8K        4
`define DSBG_SECT_W_2K        2

`endif

/* dsbg_glue.v */
// Disk sector buffer glue: host decode, control port, buffer counters,
// wait states, write precompensation select and read clock divider.
// Assumes all inputs are synchronous to CORE_CLK and the buffer RAM
// and disk controller chip sit outside this module.
`include "dsbg_defines.vh"

module dsbg_glue #(
    parameter BUF_IS_8K = 1
) (
    // Clock and reset
    input  wire        CORE_CLK,
    input  wire        ARST_N,
    // Host expansion bus
    input  wire [8:0]  HOST_ADDR,
    input  wire        HOST_ALE,
    input  wire        HOST_IO_READ_CMD_N,
    input  wire        HOST_IO_WRITE_CMD_N,
    input  wire        HOST_DATA_EN,
    input  wire        HOST_LATCH_DATA,
    output reg         IO_READY_LINE,
    output reg         HOST_IRQ_TWO_N,
    // Data transceiver control
    output reg         XCVR_TO_HOST,
    output reg         LOCAL_BUS_ENABLE_N,
    // Disk controller chip
    output reg         DISK_CTRL_SELECT_N,
    output reg  [2:0]  CTRL_REG_SEL,
    output reg         CTRL_READ_STROBE_N,
    output reg         CTRL_WRITE_STROBE_N,
    input  wire        CTRL_IRQ,
    input  wire        CTRL_BUFFER_SELECT_N,
    input  wire        CTRL_BUF_READ_N,
    input  wire        CTRL_BUF_WRITE_N,
    input  wire        CTRL_COUNT_RESET_N,
    input  wire        CTRL_DATA_REQ,
    // Control port outputs
    output reg  [2:0]  HEAD_SELECT,
    output reg         SECTOR_CLOCK_SOURCE,
    output reg         TRANSFER_DONE_FLAG,
    output reg         HOST_COUNTER_RESET,
    output reg  [1:0]  SPARE_CONTROL,
    // Buffer RAM
    output reg         BUFFER_RAM_SELECT_N,
    output reg         RAM_READ_N,
    output reg         RAM_WRITE_N,
    output reg  [12:0] RAM_ADDR,
    // Write path and read clock
    input  wire        WRITE_DATA,
    input  wire        REDUCED_WRITE_CURRENT,
    input  wire        EARLY,
    input  wire        LATE,
    output reg         PRECOMP_WRITE_DATA,
    input  wire        SEPARATOR_OSCILLATOR,
    output reg         READ_CLOCK
);

    localparam SECT_W = BUF_IS_8K ? `DSBG_SECT_W_8K : `DSBG_SECT_W_2K;
    localparam ADDR_W = `DSBG_BYTE_W + SECT_W;
    localparam TAP_LEN = `DSBG_TAP_LATE_CYC;

    // Latched host address, control port, counters, edge-detect and delay-line registers
    reg  [8:0]                addr_reg;
    reg  [7:0]                port_reg;
    reg                       latch_clk_reg;
    reg  [`DSBG_WAIT_DIV_W-1:0] div_reg;
    reg  [`DSBG_WAIT_CNT_W-1:0] wait_reg;
    reg  [`DSBG_BYTE_W-1:0]   byte_reg;
    reg  [SECT_W-1:0]         sect_reg;
    reg                       byte_clk_reg;
    reg                       req_reg;
    reg                       osc_reg;
    reg  [TAP_LEN:0]          tap_reg;

    wire [`DSBG_DEC_W-1:0]    dec_field;
    wire                      addr_stable;
    wire                      host_rd;
    wire                      host_wr;
    wire                      host_act;
    wire                      ctrl_hit;
    wire                      port_hit;
    wire                      data_hit;
    wire                      ctrl_owns;
    wire                      host_ram;
    wire                      ram_rd;
    wire                      ram_wr;
    wire                      byte_clk;
    wire                      byte_rst;
    wire                      sect_rst;
    wire                      byte_adv;
    wire                      wrap_tick;
    wire                      req_tick;
    wire                      sect_adv;
    wire                      wait_tick;
    wire                      wait_on;
    wire                      latch_clk;
    wire                      early_d;
    wire                      norm_d;
    wire                      late_d;

    // Address only trusted once the latch strobe has dropped
    assign addr_stable = ~HOST_ALE;
    assign dec_field   = addr_reg[8:4];
    assign host_rd     = ~HOST_IO_READ_CMD_N;
    assign host_wr     = ~HOST_IO_WRITE_CMD_N;
    assign host_act    = addr_stable & (host_rd | host_wr);
    assign ctrl_hit    = host_act &
                         (dec_field == `DSBG_CTRL_BASE);
    assign port_hit    = host_act & (dec_field == `DSBG_PORT_BASE) &
                         (addr_reg[0] == `DSBG_LOW_BIT_PORT);
    assign data_hit    = host_act & (dec_field == `DSBG_PORT_BASE) &
                         (addr_reg[0] == `DSBG_LOW_BIT_DATA);

    // Controller owns the buffer while its buffer select is low
    assign ctrl_owns = ~CTRL_BUFFER_SELECT_N;
    assign host_ram  = data_hit & ~ctrl_owns;
    assign ram_rd    = ctrl_owns ? ~CTRL_BUF_READ_N :
                       (host_ram & host_rd);
    assign ram_wr    = ctrl_owns ? ~CTRL_BUF_WRITE_N :
                       (host_ram & host_wr);
    assign byte_clk  = ram_rd | ram_wr;

    // Counter advances as the strobe ends, so the access sees a
    // stable address for its full length
    assign byte_adv  = byte_clk_reg & ~byte_clk;
    assign byte_rst  = port_reg[`DSBG_CP_CNT_RESET] |
                       ~CTRL_COUNT_RESET_N;
    assign sect_rst  = port_reg[`DSBG_CP_CNT_RESET];
    assign wrap_tick = byte_adv &
                       (byte_reg == `DSBG_BYTE_MAX);
    assign req_tick  = CTRL_DATA_REQ & ~req_reg;
    assign sect_adv  = port_reg[`DSBG_CP_CLKSRC] ?
                       req_tick : wrap_tick;

    // Wait states only for accesses that reach the controller or RAM
    assign wait_on   = ctrl_hit | host_ram;
    assign wait_tick = (div_reg == `DSBG_WAIT_DIV - 1);
    assign latch_clk = port_hit & host_wr;

    // Precompensation taps
    assign early_d = tap_reg[0];
    assign norm_d  = tap_reg[`DSBG_TAP_EARLY_CYC];
    assign late_d  = tap_reg[`DSBG_TAP_LATE_CYC];

    // Address latch, transparent while the strobe is high
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            addr_reg <= 9'h000;
        end else if (HOST_ALE) begin
            addr_reg <= HOST_ADDR;
        end
    end

    // Addressable control port
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            port_reg      <= `DSBG_CP_RESET;
            latch_clk_reg <= 1'b0;
        end else begin
            latch_clk_reg <= latch_clk;
            if (latch_clk & ~latch_clk_reg) begin
                port_reg[addr_reg[3:1]] <= HOST_LATCH_DATA;
            end
        end
    end

    // 5 MHz enable and wait-state counter
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            div_reg  <= {`DSBG_WAIT_DIV_W{1'b0}};
            wait_reg <= {`DSBG_WAIT_CNT_W{1'b0}};
        end else begin
            if (wait_tick) begin
                div_reg <= {`DSBG_WAIT_DIV_W{1'b0}};
            end else begin
                div_reg <= div_reg + 1'b1;
            end
            if (!wait_on) begin
                wait_reg <= {`DSBG_WAIT_CNT_W{1'b0}};
            end else if (wait_tick &&
                         !wait_reg[`DSBG_WAIT_READY_BIT]) begin
                wait_reg <= wait_reg + 1'b1;
            end
        end
    end

    // Sequential buffer address counters
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            byte_reg     <= {`DSBG_BYTE_W{1'b0}};
            sect_reg     <= {SECT_W{1'b0}};
            byte_clk_reg <= 1'b0;
            req_reg      <= 1'b0;
        end else begin
            byte_clk_reg <= byte_clk;
            req_reg      <= CTRL_DATA_REQ;
            if (byte_rst) begin
                byte_reg <= {`DSBG_BYTE_W{1'b0}};
            end else if (byte_adv) begin
                byte_reg <= byte_reg + 1'b1;
            end
            if (sect_rst) begin
                sect_reg <= {SECT_W{1'b0}};
            end else if (sect_adv) begin
                sect_reg <= sect_reg + 1'b1;
            end
        end
    end

    // Write data delay line and read clock divider
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tap_reg    <= {(TAP_LEN+1){1'b0}};
            osc_reg    <= 1'b0;
            READ_CLOCK <= 1'b0;
        end else begin
            tap_reg <= {tap_reg[TAP_LEN-1:0], WRITE_DATA};
            osc_reg <= SEPARATOR_OSCILLATOR;
            if (SEPARATOR_OSCILLATOR & ~osc_reg) begin
                READ_CLOCK <= ~READ_CLOCK;
            end
        end
    end

    // Registered outputs
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            IO_READY_LINE       <= 1'b1;
            HOST_IRQ_TWO_N      <= 1'b1;
            XCVR_TO_HOST        <= 1'b0;
            LOCAL_BUS_ENABLE_N  <= 1'b1;
            DISK_CTRL_SELECT_N  <= 1'b1;
            CTRL_REG_SEL        <= 3'h0;
            CTRL_READ_STROBE_N  <= 1'b1;
            CTRL_WRITE_STROBE_N <= 1'b1;
            HEAD_SELECT         <= 3'h0;
            SECTOR_CLOCK_SOURCE <= 1'b0;
            TRANSFER_DONE_FLAG  <= 1'b0;
            HOST_COUNTER_RESET  <= 1'b0;
            SPARE_CONTROL       <= 2'h0;
            BUFFER_RAM_SELECT_N <= 1'b1;
            RAM_READ_N          <= 1'b1;
            RAM_WRITE_N         <= 1'b1;
            RAM_ADDR            <= 13'h0000;
            PRECOMP_WRITE_DATA  <= 1'b0;
        end else begin
            IO_READY_LINE  <= ~wait_on |
                              wait_reg[`DSBG_WAIT_READY_BIT];
            HOST_IRQ_TWO_N <= ~CTRL_IRQ;
            XCVR_TO_HOST   <= host_rd;
            LOCAL_BUS_ENABLE_N <= ~(ctrl_hit | port_hit |
                                    host_ram);
            DISK_CTRL_SELECT_N  <= ~ctrl_hit;
            CTRL_REG_SEL        <= addr_reg[3:1];
            // Read held back until data enable, for register setup
            CTRL_READ_STROBE_N  <= ~(ctrl_hit & host_rd &
                                     HOST_DATA_EN);
            CTRL_WRITE_STROBE_N <= ~(ctrl_hit & host_wr);
            HEAD_SELECT <=
                port_reg[`DSBG_CP_HEAD_LSB +: `DSBG_CP_HEAD_W];
            SECTOR_CLOCK_SOURCE <= port_reg[`DSBG_CP_CLKSRC];
            TRANSFER_DONE_FLAG  <= port_reg[`DSBG_CP_XFER_DONE];
            HOST_COUNTER_RESET  <= port_reg[`DSBG_CP_CNT_RESET];
            SPARE_CONTROL       <= port_reg[`DSBG_CP_SPARE_LSB +: 2];
            BUFFER_RAM_SELECT_N <= ~(ctrl_owns | host_ram);
            RAM_READ_N          <= ~ram_rd;
            RAM_WRITE_N         <= ~ram_wr;
            // Only the counters form the address
            RAM_ADDR <= {{(13-ADDR_W){1'b0}}, sect_reg, byte_reg};
            if (!REDUCED_WRITE_CURRENT) begin
                PRECOMP_WRITE_DATA <= norm_d;
            end else if (EARLY) begin
                PRECOMP_WRITE_DATA <= early_d;
            end else if (LATE) begin
                PRECOMP_WRITE_DATA <= late_d;
            end else begin
                PRECOMP_WRITE_DATA <= norm_d;
            end
        end
    end

endmodule

/* dsbg_glue_properties.sv */
// Checker on the glue block's top ports.
// Bound from the bench top; one clock domain.
module dsbg_glue_properties (
    // Clock and reset
    input logic        CORE_CLK,
    input logic        ARST_N,
    // Host side
    input logic [8:0]  HOST_ADDR,
    input logic        HOST_ALE,
    input logic        HOST_IO_READ_CMD_N,
    input logic        HOST_DATA_EN,
    input logic        IO_READY_LINE,
    input logic        HOST_IRQ_TWO_N,
    // Controller side
    input logic        DISK_CTRL_SELECT_N,
    input logic [2:0]  CTRL_REG_SEL,
    input logic        CTRL_READ_STROBE_N,
    input logic        CTRL_IRQ,
    input logic        CTRL_BUFFER_SELECT_N,
    input logic        CTRL_COUNT_RESET_N,
    input logic        CTRL_DATA_REQ,
    // Buffer and read clock
    input logic        HOST_COUNTER_RESET,
    input logic        BUFFER_RAM_SELECT_N,
    input logic [12:0] RAM_ADDR,
    input logic        SEPARATOR_OSCILLATOR,
    input logic        READ_CLOCK
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    // Saturates so a stuck ready never wraps back into range
    logic [7:0] low_reg;
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N)
            low_reg <= 8'h00;
        else if (IO_READY_LINE)
            low_reg <= 8'h00;
        else if (low_reg != 8'hFF)
            low_reg <= low_reg + 8'h01;
    end
    sequence s_host_clear;
        HOST_COUNTER_RESET [*3];
    endsequence
    sequence s_ctrl_clear;
        (!CTRL_COUNT_RESET_N && !CTRL_DATA_REQ && !HOST_COUNTER_RESET) [*4];
    endsequence
    chk_irq_follow: assert property (HOST_IRQ_TWO_N == !$past(CTRL_IRQ))
        else $error("host interrupt does not follow");
    chk_ctrl_decode: assert property (!DISK_CTRL_SELECT_N |->
        $past(HOST_ADDR) < 9'h010 && !$past(HOST_ALE))
        else $error("controller select outside its range");
    chk_reg_select: assert property (!DISK_CTRL_SELECT_N |->
        CTRL_REG_SEL == HOST_ADDR[3:1])
        else $error("register select differs from address");
    chk_read_qual: assert property (!CTRL_READ_STROBE_N |->
        $past(HOST_DATA_EN) && !$past(HOST_IO_READ_CMD_N))
        else $error("controller read without data enable");
    chk_ready_range: assert property ($rose(IO_READY_LINE) |->
        low_reg inside {[8'h3D:8'h50]})
        else $error("wait length out of range");
    chk_ready_bound: assert property (!IO_READY_LINE |-> low_reg < 8'h50)
        else $error("ready held low too long");
    chk_buf_owner: assert property (!$past(CTRL_BUFFER_SELECT_N) |->
        !BUFFER_RAM_SELECT_N)
        else $error("buffer select missing for controller");
    chk_count_clear: assert property (s_host_clear |-> RAM_ADDR == 13'h0000)
        else $error("host reset left counters set");
    chk_sector_keep: assert property (s_ctrl_clear |->
        RAM_ADDR[8:0] == 9'h000 && $stable(RAM_ADDR[12:9]))
        else $error("controller reset misbehaves");
    chk_read_clock: assert property ($rose(SEPARATOR_OSCILLATOR) |->
        ##1 $changed(READ_CLOCK))
        else $error("read clock did not toggle");
endmodule

/* dsbg_host_model.sv */
// Host processor model on the expansion-bus side.
// Changes requests just after an edge; ready sampled on edges.
module dsbg_host_model (
    // Clock and ready
    input  logic       clk,
    input  logic       ready,
    // Bus outputs
    output logic [8:0] addr,
    output logic       ale,
    output logic       rd_n,
    output logic       wr_n,
    output logic       den,
    output logic       ldata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {addr, ale, rd_n, wr_n, den, ldata} = {9'h1FF, 5'h0C};
    end
    // One byte cycle; waits counts edges with ready low
    task automatic access(input logic [8:0] a, input logic wr,
                          input logic d, output int waits);
        waits = 0;
        @(posedge clk);
        addr <= a;
        ale <= 1'h1;
        @(posedge clk);
        ale <= 1'h0;
        rd_n <= wr;
        wr_n <= !wr;
        den <= !wr;
        ldata <= d;
        repeat (3) @(posedge clk);
        while (ready !== 1'h1 && waits < 200) begin
            @(posedge clk);
            waits++;
        end
        {rd_n, wr_n, den} <= 3'h6;
        @(posedge clk);
    endtask
endmodule

/* dsbg_glue_test.sv */
// Self-checking bench for the disk sector buffer glue block.
// Needs the host model and checker; signals named as the glue's ports.
module dsbg_glue_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic CORE_CLK, ARST_N, HOST_ALE, HOST_DATA_EN, HOST_LATCH_DATA;
    logic HOST_IO_READ_CMD_N, HOST_IO_WRITE_CMD_N, IO_READY_LINE;
    logic HOST_IRQ_TWO_N, XCVR_TO_HOST, LOCAL_BUS_ENABLE_N;
    logic DISK_CTRL_SELECT_N, CTRL_READ_STROBE_N, CTRL_WRITE_STROBE_N;
    logic SECTOR_CLOCK_SOURCE, TRANSFER_DONE_FLAG, HOST_COUNTER_RESET;
    logic BUFFER_RAM_SELECT_N, RAM_READ_N, RAM_WRITE_N;
    logic PRECOMP_WRITE_DATA, READ_CLOCK;
    logic [8:0]  HOST_ADDR;
    logic [2:0]  CTRL_REG_SEL, HEAD_SELECT;
    logic [1:0]  SPARE_CONTROL;
    logic [12:0] RAM_ADDR;
    logic CTRL_IRQ = 1'h0, CTRL_BUFFER_SELECT_N = 1'h1, CTRL_BUF_READ_N = 1'h1;
    logic CTRL_BUF_WRITE_N = 1'h1, CTRL_COUNT_RESET_N = 1'h1;
    logic CTRL_DATA_REQ = 1'h0, WRITE_DATA = 1'h0, SEPARATOR_OSCILLATOR = 1'h0;
    logic EARLY = 1'h0, LATE = 1'h0, REDUCED_WRITE_CURRENT = 1'h0;
    logic [2:0]  pcnt = 3'h0;
    logic [3:0]  hist = 4'h0;
    logic [2:0]  modes [4] = '{3'h0, 3'h6, 3'h5, 3'h4};
    // Tap depth plus the output register
    int          dly [4] = '{2, 1, 3, 2};
    int          mismatches = 0, checks_done = 0, w, k, lbe_lows = 0;
    typedef struct packed {logic [8:0] a; logic d; logic [5:0] e;} dsbg_row_t;
    dsbg_row_t rows [9] = '{'{9'h010, 1'h1, 6'h01}, '{9'h012, 1'h1, 6'h03},
        '{9'h014, 1'h1, 6'h07}, '{9'h016, 1'h1, 6'h0F}, '{9'h018, 1'h1, 6'h1F},
        '{9'h01A, 1'h1, 6'h3F}, '{9'h01A, 1'h0, 6'h1F}, '{9'h016, 1'h0, 6'h17},
        '{9'h010, 1'h0, 6'h16}};
    dsbg_glue uut (.*);
    dsbg_host_model host (.clk(CORE_CLK), .ready(IO_READY_LINE),
        .addr(HOST_ADDR), .ale(HOST_ALE), .rd_n(HOST_IO_READ_CMD_N),
        .wr_n(HOST_IO_WRITE_CMD_N), .den(HOST_DATA_EN),
        .ldata(HOST_LATCH_DATA));
    initial begin
        CORE_CLK = 1'h0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end
    // Write data pattern whose shifts all differ
    always @(posedge CORE_CLK) begin
        pcnt <= pcnt + 3'h1;
        WRITE_DATA <= ^pcnt;
        SEPARATOR_OSCILLATOR <= pcnt[1];
        hist <= {hist[2:0], WRITE_DATA};
    end
    // Counted off the edge so a snapshot taken on the edge never races it
    always @(negedge CORE_CLK) begin
        if (LOCAL_BUS_ENABLE_N === 1'h0)
            lbe_lows++;
    end
    task automatic check(input string what, input logic [12:0] exp, got);
        checks_done++;
        if (exp !== got) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test;
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge CORE_CLK);
            CTRL_BUF_WRITE_N <= 1'h0;
            repeat (2) @(posedge CORE_CLK);
            CTRL_BUF_WRITE_N <= 1'h1;
        end
        repeat (3) @(negedge CORE_CLK);
    endtask
    initial begin
        ARST_N = 1'h0;
        repeat (20) @(posedge CORE_CLK);
        ARST_N <= 1'h1;
        foreach (rows[i]) begin
            host.access(rows[i].a, 1'h1, rows[i].d, w);
            repeat (2) @(negedge CORE_CLK);
            check("port wait", 13'h0000, w[12:0]);
            check("port", {7'h00, rows[i].e}, {7'h00, HOST_COUNTER_RESET,
                TRANSFER_DONE_FLAG, SECTOR_CLOCK_SOURCE, HEAD_SELECT});
        end
        host.access(9'h006, 1'h0, 1'h0, w);
        check("ctrl wait", 13'h0001, {12'h000, w inside {[59:80]}});
        k = lbe_lows;
        host.access(9'h1F0, 1'h1, 1'h1, w);
        check("unmapped", k[12:0], lbe_lows[12:0]);
        @(posedge CORE_CLK);
        CTRL_IRQ <= 1'h1;
        repeat (2) @(negedge CORE_CLK);
        check("irq", 13'h0000, {12'h000, HOST_IRQ_TWO_N});
        @(posedge CORE_CLK);
        CTRL_BUFFER_SELECT_N <= 1'h0;
        pulse(5);
        check("byte", 13'h0005, RAM_ADDR);
        pulse(507);
        check("wrap", 13'h0200, RAM_ADDR);
        host.access(9'h011, 1'h1, 1'h0, w);
        check("owned", 13'h0200, RAM_ADDR);
        @(posedge CORE_CLK);
        CTRL_BUFFER_SELECT_N <= 1'h1;
        host.access(9'h011, 1'h1, 1'h0, w);
        repeat (3) @(negedge CORE_CLK);
        check("host byte", 13'h0201, RAM_ADDR);
        host.access(9'h016, 1'h1, 1'h1, w);
        @(posedge CORE_CLK);
        CTRL_DATA_REQ <= 1'h1;
        @(posedge CORE_CLK);
        CTRL_DATA_REQ <= 1'h0;
        repeat (4) @(negedge CORE_CLK);
        check("request", 13'h0401, RAM_ADDR);
        @(posedge CORE_CLK);
        CTRL_COUNT_RESET_N <= 1'h0;
        repeat (5) @(posedge CORE_CLK);
        CTRL_COUNT_RESET_N <= 1'h1;
        @(negedge CORE_CLK);
        check("ctrl clear", 13'h0400, RAM_ADDR);
        host.access(9'h01A, 1'h1, 1'h1, w);
        repeat (3) @(negedge CORE_CLK);
        check("host clear", 13'h0000, RAM_ADDR);
        host.access(9'h01A, 1'h1, 1'h0, w);
        for (int m = 0; m < 4; m++) begin
            @(posedge CORE_CLK);
            {REDUCED_WRITE_CURRENT, EARLY, LATE} <= modes[m];
            repeat (4) @(negedge CORE_CLK);
            repeat (3) begin
                @(negedge CORE_CLK);
                check("precomp", {12'h000, hist[dly[m]]},
                    {12'h000, PRECOMP_WRITE_DATA});
            end
        end
        stop_test;
    end
    // Whole run is about two thousand cycles; this leaves wide margin
    initial begin
        #200000;
        mismatches++;
        stop_test;
    end
endmodule
bind dsbg_glue dsbg_glue_properties chk (.*);
